// *** logic/amcp_pkg.sv ***
package amcp_pkg;
  localparam logic [6:0] AMCP_ADR_SRST  = 7'h00;
  localparam logic [6:0] AMCP_ADR_PWR   = 7'h01;
  localparam logic [6:0] AMCP_ADR_TIM   = 7'h02;
  localparam logic [6:0] AMCP_ADR_OMODE = 7'h03;
  localparam logic [6:0] AMCP_ADR_FMT   = 7'h04;
  localparam logic [7:0] AMCP_REG_RST   = 8'h00;
  localparam int AMCP_SRST_BIT   = 7;
  localparam int AMCP_WORD_BITS  = 16;
  localparam int AMCP_HDR_BITS   = 8;
  localparam int AMCP_DATA_BITS  = 12;
  localparam int AMCP_P_STRAP = 3;
  localparam int AMCP_P_CS    = 2;
  localparam int AMCP_P_SCK   = 1;
  localparam int AMCP_P_SDI   = 0;
  // Pin sampler preset: parallel strap and an idle chip-select, so reset shows no false edge.
  localparam logic [3:0] AMCP_PIN_IDLE = 4'hc;
  localparam logic [4:0] AMCP_CNT_WORD = 5'h10;
  localparam logic [4:0] AMCP_CNT_HDR  = 5'h07;
  localparam logic [4:0] AMCP_CNT_TX_LO = 5'h09;
  localparam logic [4:0] AMCP_CNT_TX_HI = 5'h0f;
  localparam logic [1:0] AMCP_PWR_NORMAL = 2'h0;
  localparam logic [1:0] AMCP_PWR_NAP    = 2'h1;
  localparam logic [1:0] AMCP_PWR_SLEEP  = 2'h3;
  localparam logic [1:0] AMCP_STY_FULL_SE = 2'h0;
  localparam logic [1:0] AMCP_STY_DDR_DIF = 2'h1;
  localparam logic [1:0] AMCP_STY_DDR_SE  = 2'h2;
  localparam logic [2:0] AMCP_CUR_3P5MA = 3'h0;
  localparam logic [2:0] AMCP_PAT_OFF   = 3'h0;
  localparam logic [2:0] AMCP_PAT_ZERO  = 3'h1;
  localparam logic [2:0] AMCP_PAT_ONE   = 3'h3;
  localparam logic [2:0] AMCP_PAT_CHECK = 3'h5;
  localparam logic [2:0] AMCP_PAT_ALT   = 3'h7;
  localparam logic [12:0] AMCP_CHECK_A = 13'h1555;
  localparam logic [11:0] AMCP_ODD_MASK = 12'haaa;
endpackage

// *** logic/amcp_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Strap high makes serial pins static levels.
// - Parallel: chip-select sets duty stabilizer.
// - Parallel: clock pin picks full-rate or DDR.
// - Parallel: data-in pin high means sleep.
// - Strap low makes pins a serial port.
// - Only first 16 rising clock edges sampled.
// - Word is rw, 7-bit address, 8 data.
// - Write flag low stores data bits.
// - Read returns register, unchanged, input ignored.
// - Reset bit clears all registers, self-clears.
// - Power field: normal, nap, sleep.
// - Timing: clock invert and phase delay.
// - Timing bit 0 enables duty stabilizer.
// - Drive current code and termination enable.
// - Output-disable bit tristates digital outputs.
// - Output style field selects output mode.
// - Format field selects test patterns.
// - Format bit 2 enables odd-bit inversion.
// - Format bit 1 enables LSB scrambler.
// - Bit 0 signed; odd-bit invert forces offset.
// - Scrambler XORs upper bits with LSB.
// - Odd-bit mode inverts odd data bits.
// - Test pattern overrides all formatting.
module amcp_top
  import amcp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        strap_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic        sdi_pin,
  input  wire logic [11:0] sample_code,
  input  wire logic        sample_ovr,
  input  wire logic        sample_valid,
  output logic             sdo_o,
  output logic             sdo_oe,
  output logic             duty_stabilizer_en,
  output logic [1:0]       power_state_field,
  output logic             clk_out_invert,
  output logic [1:0]       clk_out_delay_sel,
  output logic [2:0]       diff_drive_current_sel,
  output logic             diff_term_en,
  output logic             output_tristate,
  output logic [1:0]       output_style_sel,
  output logic [11:0]      fmt_data,
  output logic             overrange_flag,
  output logic             fmt_valid
);
  logic [3:0]  pin_s1_r;
  logic [3:0]  pin_s2_r;
  logic        sck_d_r;
  logic        cs_d_r;
  logic [4:0]  bit_cnt_r;
  logic [15:0] shift_r;
  logic [6:0]  tx_r;
  logic        rd_act_r;
  logic [1:0]  pwr_r;
  logic [3:0]  tim_r;
  logic [6:0]  omode_r;
  logic [5:0]  fmt_r;
  logic        phase_r;
  logic        parallel;
  logic        active;
  logic        sck_rise;
  logic        sck_fall;
  logic        word_end;
  logic        commit_wr;
  logic        commit_rd;
  logic        soft_rst;
  logic        hdr_done;
  logic [6:0]  hdr_adr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [2:0]  pattern_sel;
  logic        odd_bit_invert_en;
  logic        lsb_scramble_en;
  logic        signed_format_en;
  logic [11:0] code_w;

  // Pins come from another domain; the first stage feeds only the second.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_s1_r <= AMCP_PIN_IDLE;
      pin_s2_r <= AMCP_PIN_IDLE;
      sck_d_r  <= 1'b0;
      cs_d_r   <= 1'b1;
    end else if (clk_en) begin
      pin_s1_r <= {strap_pin, cs_n_pin, sck_pin, sdi_pin};
      pin_s2_r <= pin_s1_r;
      sck_d_r  <= pin_s2_r[AMCP_P_SCK];
      cs_d_r   <= pin_s2_r[AMCP_P_CS];
    end
  end

  assign parallel = pin_s2_r[AMCP_P_STRAP];
  assign active   = ~parallel & ~pin_s2_r[AMCP_P_CS];
  assign sck_rise = pin_s2_r[AMCP_P_SCK] & ~sck_d_r;
  assign sck_fall = ~pin_s2_r[AMCP_P_SCK] & sck_d_r;
  assign word_end = ~parallel & pin_s2_r[AMCP_P_CS] & ~cs_d_r;
  assign hdr_done = active & sck_rise & (bit_cnt_r == AMCP_CNT_HDR);
  assign hdr_adr  = {shift_r[5:0], pin_s2_r[AMCP_P_SDI]};
  assign wr_data  = shift_r[7:0];
  // A short word is dropped whole rather than half-applied.
  assign commit_wr = word_end & (bit_cnt_r == AMCP_CNT_WORD) & ~shift_r[15];
  assign commit_rd = word_end & (bit_cnt_r == AMCP_CNT_WORD) & shift_r[15];
  assign soft_rst  = commit_wr & (shift_r[14:8] == AMCP_ADR_SRST)
                     & wr_data[AMCP_SRST_BIT];

  always_comb begin
    rd_data = 8'h00;
    unique case (hdr_adr)
      AMCP_ADR_PWR:   rd_data = {6'h00, pwr_r};
      AMCP_ADR_TIM:   rd_data = {4'h0, tim_r};
      AMCP_ADR_OMODE: rd_data = {1'b0, omode_r};
      AMCP_ADR_FMT:   rd_data = {2'h0, fmt_r};
      default:        rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= 16'h0000;
    end else if (clk_en) begin
      if (!active) begin
        bit_cnt_r <= 5'h00;
      end else if (sck_rise && bit_cnt_r < AMCP_CNT_WORD) begin
        shift_r   <= {shift_r[14:0], pin_s2_r[AMCP_P_SDI]};
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // Open drain: the pin is only ever pulled low, so sdo_o stays zero.
  // The command bit keeps moving through the shifter, so a read is latched at the header.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sdo_o    <= 1'b0;
      sdo_oe   <= 1'b0;
      tx_r     <= 7'h00;
      rd_act_r <= 1'b0;
    end else if (clk_en) begin
      sdo_o <= 1'b0;
      if (!active) begin
        sdo_oe   <= 1'b0;
        rd_act_r <= 1'b0;
      end else if (hdr_done && shift_r[6]) begin
        sdo_oe   <= ~rd_data[7];
        tx_r     <= rd_data[6:0];
        rd_act_r <= 1'b1;
      end else if (sck_fall && bit_cnt_r >= AMCP_CNT_TX_LO
                   && bit_cnt_r <= AMCP_CNT_TX_HI && rd_act_r) begin
        sdo_oe <= ~tx_r[6];
        tx_r   <= {tx_r[5:0], 1'b0};
      end else if (sck_rise && bit_cnt_r == AMCP_CNT_TX_HI) begin
        sdo_oe <= sdo_oe;
      end else if (bit_cnt_r == AMCP_CNT_WORD && sck_fall) begin
        sdo_oe <= 1'b0;
      end
    end
  end

  // The reset register holds nothing; its bit acts at the word's end.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_r   <= AMCP_REG_RST[1:0];
      tim_r   <= AMCP_REG_RST[3:0];
      omode_r <= AMCP_REG_RST[6:0];
      fmt_r   <= AMCP_REG_RST[5:0];
    end else if (clk_en) begin
      if (soft_rst) begin
        pwr_r   <= AMCP_REG_RST[1:0];
        tim_r   <= AMCP_REG_RST[3:0];
        omode_r <= AMCP_REG_RST[6:0];
        fmt_r   <= AMCP_REG_RST[5:0];
      end else if (commit_wr) begin
        unique case (shift_r[14:8])
          AMCP_ADR_PWR:   pwr_r   <= wr_data[1:0];
          AMCP_ADR_TIM:   tim_r   <= wr_data[3:0];
          AMCP_ADR_OMODE: omode_r <= wr_data[6:0];
          AMCP_ADR_FMT:   fmt_r   <= wr_data[5:0];
          default:        pwr_r   <= pwr_r;
        endcase
      end
    end
  end

  // Mode outputs: pin levels or fixed values in the parallel style, registers otherwise.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      duty_stabilizer_en     <= 1'b0;
      power_state_field      <= AMCP_PWR_NORMAL;
      clk_out_invert         <= 1'b0;
      clk_out_delay_sel      <= 2'h0;
      diff_drive_current_sel <= AMCP_CUR_3P5MA;
      diff_term_en           <= 1'b0;
      output_tristate        <= 1'b0;
      output_style_sel       <= AMCP_STY_FULL_SE;
    end else if (clk_en) begin
      if (parallel) begin
        duty_stabilizer_en     <= pin_s2_r[AMCP_P_CS];
        output_style_sel       <= pin_s2_r[AMCP_P_SCK]
                                  ? AMCP_STY_DDR_DIF : AMCP_STY_FULL_SE;
        diff_drive_current_sel <= AMCP_CUR_3P5MA;
        diff_term_en           <= 1'b0;
        power_state_field      <= pin_s2_r[AMCP_P_SDI]
                                  ? AMCP_PWR_SLEEP : AMCP_PWR_NORMAL;
        clk_out_invert         <= 1'b0;
        clk_out_delay_sel      <= 2'h0;
        output_tristate        <= 1'b0;
      end else begin
        duty_stabilizer_en     <= tim_r[0];
        clk_out_invert         <= tim_r[3];
        clk_out_delay_sel      <= tim_r[2:1];
        power_state_field      <= pwr_r;
        diff_drive_current_sel <= omode_r[6:4];
        diff_term_en           <= omode_r[3];
        output_tristate        <= omode_r[2];
        output_style_sel       <= omode_r[1:0];
      end
    end
  end

  assign pattern_sel       = parallel ? AMCP_PAT_OFF : fmt_r[5:3];
  assign odd_bit_invert_en = ~parallel & fmt_r[2];
  assign lsb_scramble_en   = ~parallel & fmt_r[1];
  assign signed_format_en  = ~parallel & fmt_r[0] & ~fmt_r[2];

  always_comb begin
    code_w = sample_code;
    if (signed_format_en) begin
      code_w[11] = ~code_w[11];
    end
    if (lsb_scramble_en) begin
      code_w[11:1] = code_w[11:1] ^ {11{code_w[0]}};
    end
    if (odd_bit_invert_en) begin
      code_w = code_w ^ AMCP_ODD_MASK;
    end
  end

  // Unused pattern codes fall back to normal data.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fmt_data       <= 12'h000;
      overrange_flag <= 1'b0;
      fmt_valid      <= 1'b0;
      phase_r        <= 1'b0;
    end else if (clk_en) begin
      fmt_valid <= sample_valid;
      if (sample_valid) begin
        phase_r <= ~phase_r;
        unique case (pattern_sel)
          AMCP_PAT_ZERO: {overrange_flag, fmt_data} <= 13'h0000;
          AMCP_PAT_ONE:  {overrange_flag, fmt_data} <= 13'h1fff;
          AMCP_PAT_CHECK: {overrange_flag, fmt_data} <=
            phase_r ? ~AMCP_CHECK_A : AMCP_CHECK_A;
          AMCP_PAT_ALT:  {overrange_flag, fmt_data} <=
            {13{phase_r}};
          default: begin
            fmt_data       <= code_w;
            overrange_flag <= sample_ovr;
          end
        endcase
      end
    end
  end

  a_par_stabilizer: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && parallel |=> duty_stabilizer_en == $past(pin_s2_r[AMCP_P_CS]))
    else $error("Stabilizer does not follow chip-select pin.");

  a_par_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && parallel && pin_s2_r[AMCP_P_SDI]
    |=> power_state_field == AMCP_PWR_SLEEP)
    else $error("Data-in pin high did not select sleep.");

  a_par_style: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && parallel && pin_s2_r[AMCP_P_SCK]
    |=> output_style_sel == AMCP_STY_DDR_DIF && !diff_term_en)
    else $error("Clock pin high did not select DDR differential.");

  a_edge_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
    bit_cnt_r <= AMCP_CNT_WORD)
    else $error("More than sixteen bits were sampled.");

  a_write_pwr: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && commit_wr && shift_r[14:8] == AMCP_ADR_PWR
    |=> pwr_r == $past(shift_r[1:0]))
    else $error("Write did not store power field.");

  a_read_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && commit_rd |=> $stable(fmt_r) && $stable(omode_r) && $stable(tim_r))
    else $error("Read command changed a register.");

  a_soft_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && soft_rst |=> pwr_r == 2'h0 && tim_r == 4'h0 && fmt_r == 6'h00)
    else $error("Software reset did not clear registers.");

  a_sdo_msb: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && hdr_done && shift_r[6] |=> sdo_oe == !$past(rd_data[7]))
    else $error("Read data MSB not presented.");

  a_sdo_shift: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && active && rd_act_r && sck_fall && bit_cnt_r >= AMCP_CNT_TX_LO
    && bit_cnt_r <= AMCP_CNT_TX_HI |=> sdo_oe == !$past(tx_r[6]))
    else $error("Read data bit not shifted out.");

  a_pat_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && sample_valid && pattern_sel == AMCP_PAT_ZERO
    |=> fmt_data == 12'h000 && !overrange_flag)
    else $error("Zero pattern not forced.");

  a_scramble: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && sample_valid && pattern_sel == AMCP_PAT_OFF && lsb_scramble_en
    && !odd_bit_invert_en |=> fmt_data[0] == $past(sample_code[0]))
    else $error("Scrambler changed the LSB.");
endmodule // amcp_top
`default_nettype wire

// *** testbench/amcp_spi_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module amcp_spi_master (
  input  wire logic core_clk,
  input  wire logic sdo_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  logic sdo_line;
  // The line has a pull-up, so it reads high whenever the device lets go.
  assign sdo_line = ~sdo_oe;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Serial clock half period is eight core cycles, well above the sampler's need.
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    wt(1);
    cs_n <= 1'b0;
    wt(8);
    for (int i = 0; i < n; i++) begin
      sdi <= (i < 16) ? w[15-i] : ~sdi;
      wt(8);
      sck <= 1'b1;
      rd = {rd[6:0], sdo_line};
      wt(8);
      sck <= 1'b0;
    end
    wt(8);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    wt(16);
  endtask
endmodule // amcp_spi_master
`default_nettype wire

// *** testbench/test_adc_mode_config_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_adc_mode_config_port;
  import amcp_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        strap_pin = 1'b1;
  logic [2:0]  par = 3'h0;
  logic        cs_m, sck_m, sdi_m, cs_n_pin, sck_pin, sdi_pin;
  logic [11:0] sample_code = 12'h3c5;
  logic        sample_ovr = 1'b1;
  logic        sample_valid = 1'b0;
  logic        sdo_o, sdo_oe, duty_stabilizer_en, clk_out_invert, diff_term_en;
  logic        output_tristate, overrange_flag, fmt_valid;
  logic [1:0]  power_state_field, clk_out_delay_sel, output_style_sel;
  logic [2:0]  diff_drive_current_sel;
  logic [11:0] fmt_data;
  logic [7:0]  rd;
  logic [12:0] g1, g2, e, modes;
  int          mismatches = 0;
  int          total_checks = 0;
  always #5 core_clk = ~core_clk;
  // Parallel levels come from the bench, serial traffic from the master model.
  assign cs_n_pin = strap_pin ? par[2] : cs_m;
  assign sck_pin = strap_pin ? par[1] : sck_m;
  assign sdi_pin = strap_pin ? par[0] : sdi_m;
  assign modes = {duty_stabilizer_en, power_state_field, clk_out_invert, clk_out_delay_sel,
    diff_drive_current_sel, diff_term_en, output_tristate, output_style_sel};
  amcp_top dut (.core_clk, .sys_rst, .clk_en, .strap_pin, .cs_n_pin, .sck_pin, .sdi_pin,
    .sample_code, .sample_ovr, .sample_valid, .sdo_o, .sdo_oe, .duty_stabilizer_en,
    .power_state_field, .clk_out_invert, .clk_out_delay_sel, .diff_drive_current_sel,
    .diff_term_en, .output_tristate, .output_style_sel, .fmt_data, .overrange_flag,
    .fmt_valid);
  amcp_spi_master m (.core_clk, .sdo_oe, .cs_n(cs_m), .sck(sck_m), .sdi(sdi_m));
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    m.xfer({1'b0, a, d}, n, rd);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] x);
    m.xfer({1'b1, a, 8'hff}, 16, rd);
    chk({5'h00, rd}, {5'h00, x});
  endtask
  task automatic samp(output logic [12:0] g);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    #1;
    chk({12'h000, fmt_valid}, 13'h0001);
    g = {overrange_flag, fmt_data};
  endtask
  function automatic logic [11:0] expf(input logic [7:0] f, input logic [11:0] c);
    logic [11:0] d;
    d = c;
    if (f[0] && !f[2]) d[11] = ~d[11];
    if (f[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
    if (f[2]) d = d ^ AMCP_ODD_MASK;
    return d;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      par <= k[2:0];
      repeat (6) @(posedge core_clk);
      #1;
      e = {par[2], par[0] ? AMCP_PWR_SLEEP : AMCP_PWR_NORMAL, 3'h0, AMCP_CUR_3P5MA, 2'h0,
        par[1] ? AMCP_STY_DDR_DIF : AMCP_STY_FULL_SE};
      chk(modes, e);
      chk({11'h000, sdo_o, sdo_oe}, 13'h0000);
    end
    @(posedge core_clk);
    strap_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(AMCP_ADR_SRST, 8'h80);
    wr(AMCP_ADR_PWR, 8'h01);
    wr(AMCP_ADR_TIM, 8'h0b);
    wr(AMCP_ADR_OMODE, 8'h2d);
    e = {1'b1, AMCP_PWR_NAP, 1'b1, 2'h1, 3'h2, 2'h3, AMCP_STY_DDR_DIF};
    chk(modes, e);
    rdchk(AMCP_ADR_PWR, 8'h01);
    rdchk(AMCP_ADR_TIM, 8'h0b);
    rdchk(AMCP_ADR_OMODE, 8'h2d);
    chk(modes, e);
    rdchk(AMCP_ADR_SRST, 8'h00);
    wr(7'h05, 8'h5a);
    rdchk(7'h05, 8'h00);
    chk(modes, e);
    wr(AMCP_ADR_PWR, 8'h03, 20);
    e[11:10] = AMCP_PWR_SLEEP;
    chk(modes, e);
    wr(AMCP_ADR_PWR, 8'h00, 15);
    chk(modes, e);
    wr(AMCP_ADR_OMODE, 8'h72);
    e[6:0] = {3'h7, 2'h0, AMCP_STY_DDR_SE};
    chk(modes, e);
    for (int f = 0; f < 8; f++) begin
      wr(AMCP_ADR_FMT, f[7:0]);
      samp(g1);
      chk(g1, {1'b1, expf(f[7:0], sample_code)});
    end
    for (int p = 1; p < 8; p += 2) begin
      wr(AMCP_ADR_FMT, {2'h0, p[2:0], 3'h7});
      samp(g1);
      samp(g2);
      e = (p == 3) ? 13'h1fff : (p == 5) ? AMCP_CHECK_A : 13'h0000;
      if (p < 5) begin
        chk(g1, e);
        chk(g2, e);
      end else begin
        chk(g1 ^ g2, 13'h1fff);
        chk({12'h000, (g1 == e) || (g1 == ~e)}, 13'h0001);
      end
    end
    wr(AMCP_ADR_SRST, 8'h80);
    chk(modes, 13'h0000);
    rdchk(AMCP_ADR_FMT, 8'h00);
    // A word sent while the clock enable is low must leave no trace.
    clk_en <= 1'b0;
    wr(AMCP_ADR_PWR, 8'h03);
    clk_en <= 1'b1;
    chk(modes, 13'h0000);
    rdchk(AMCP_ADR_PWR, 8'h00);
    end_of_test();
  end
endmodule // test_adc_mode_config_port
`default_nettype wire
